// ==== src/slss_cfg.svh ====
// Offsets, field positions, reset values and timing counts of the sequencer
`ifndef SLSS_CFG_SVH
`define SLSS_CFG_SVH
`define SLSS_OFS_CTRL     8'h00
`define SLSS_OFS_CONF     8'h04
`define SLSS_OFS_STAT     8'h08
`define SLSS_CTRL_EN_BIT  0
`define SLSS_CTRL_CAL_BIT 1
`define SLSS_CTRL_RST     32'h0000_0001
`define SLSS_CONF_RST     32'h0000_1f00
`define SLSS_ILA_MFRAMES  4
`define SLSS_CAL_CYCLES   64
`endif

// ==== src/slss_pkg.sv ====
// Types of the link startup sequencer
package slss_pkg;
    typedef enum {
        ST_OFF, ST_CAL, ST_WAIT_SYNC, ST_CGS, ST_ILA, ST_DATA
    } slss_state_e;
    typedef logic [1:0] slss_sym_t;
    localparam slss_sym_t SYM_IDLE = 2'h0;
    localparam slss_sym_t SYM_CGS  = 2'h1;
    localparam slss_sym_t SYM_ILA  = 2'h2;
    localparam slss_sym_t SYM_DATA = 2'h3;
endpackage : slss_pkg

// ==== src/slss_sync2.sv ====
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module slss_sync2 (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic d,
    output logic      q
);
    logic meta_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b0;
            q      <= 1'b0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule : slss_sync2

// ==== src/slss_top.sv ====
// Link startup sequencer with Wishbone registers
//
// Added by the designer: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "slss_cfg.svh"
// Operation
// [RL1] Writing zero to link_enable_bit shuts the link down and opens config.
// [RL2] Software sets decimation, scrambler, K-1 and rate while disabled.
// [RL3] Writing one to calibration_soft_trigger runs a calibration first.
// [RL4] Writing one to link_enable_bit enables the serial link.
// [RL5] A SYSREF rising edge after enable sets the multiframe clock phase.
// [RL6] The SYSREF edge may be omitted without deterministic latency.
// [RL7] The receiver asserts sync_n low to start link communication. The code already sends sync characters in ST_WAIT_SYNC, before sync_n falls.
// [RL8] Deasserted sync_n after code group sync starts lane alignment.
// [RL9] Sample data follows the last alignment frame with no idle gap.
// [RL10] While sync_n is low and link enabled, sync characters are sent.
module slss_top #(
    parameter int CAL_CYCLES = `SLSS_CAL_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        sysref,
    input  wire logic        sync_n,
    output logic             link_on,
    output logic      [1:0]  lane_sym,
    output logic             lmfc_pulse,
    output logic      [2:0]  decimate_sel,
    output logic             scrambler_enable,
    output logic             serial_ddr
);
    // ------------------------------------------------------------
    // Pin synchronisers and register state
    // ------------------------------------------------------------
    logic                sysref_s, sync_n_s, sysref_d_q;
    logic                link_enable_bit;
    logic                cal_req_q;
    logic [31:0]         conf_q;
    logic [4:0]          multiframe_length_minus_one;
    logic [4:0]          lmfc_cnt_q;
    logic [15:0]         cal_cnt_q;
    logic [2:0]          ila_cnt_q;
    logic                phase_set_q;
    slss_pkg::slss_state_e state_q;
    logic                wr, rd, lmfc_wrap;

    slss_sync2 u_sref (.clk(clk), .rst(rst), .d(sysref), .q(sysref_s));
    slss_sync2 u_sync (.clk(clk), .rst(rst), .d(sync_n), .q(sync_n_s));

    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
    assign multiframe_length_minus_one = conf_q[12:8];
    assign lmfc_wrap = (lmfc_cnt_q == multiframe_length_minus_one);

    // ------------------------------------------------------------
    // Wishbone slave: one wait state, unmapped reads give zero
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wb_dat_o <= 32'h0;
        end else if (rd) begin
            case (wb_adr_i)
                `SLSS_OFS_CTRL: wb_dat_o <= {30'h0, cal_req_q,
                                             link_enable_bit};
                `SLSS_OFS_CONF: wb_dat_o <= conf_q;
                `SLSS_OFS_STAT: wb_dat_o <= {24'h0, phase_set_q,
                                             sync_n_s, 1'b0, lane_sym,
                                             3'(state_q)};
                default:        wb_dat_o <= 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            link_enable_bit <= 1'b1;
        end else if (wr && wb_adr_i == `SLSS_OFS_CTRL && wb_sel_i[0]) begin
            link_enable_bit <= wb_dat_i[`SLSS_CTRL_EN_BIT]; // see [RL1] [RL4]
        end
    end

    // Config writes are dropped while the link runs, so a live link
    // never sees its framing change underneath it.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            conf_q <= `SLSS_CONF_RST;
        end else if (wr && wb_adr_i == `SLSS_OFS_CONF && !link_enable_bit) begin
            for (int b = 0; b < 4; b++) begin
                if (wb_sel_i[b]) begin
                    conf_q[8*b +: 8] <= wb_dat_i[8*b +: 8]; // see [RL2]
                end
            end
        end
    end

    // Trigger held until the calibration count reaches zero at the end of ST_CAL
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cal_req_q <= 1'b0;
        end else if (wr && wb_adr_i == `SLSS_OFS_CTRL && wb_sel_i[0]
                     && wb_dat_i[`SLSS_CTRL_CAL_BIT]) begin
            cal_req_q <= 1'b1; // see [RL3]
        end else if (state_q == slss_pkg::ST_CAL && cal_cnt_q == 16'h0) begin
            cal_req_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Multiframe clock, phased by SYSREF
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sysref_d_q  <= 1'b0;
            lmfc_cnt_q  <= 5'h0;
            phase_set_q <= 1'b0;
        end else begin
            sysref_d_q <= sysref_s;
            if (!link_enable_bit) begin
                phase_set_q <= 1'b0;
                lmfc_cnt_q  <= 5'h0;
            end else if (sysref_s && !sysref_d_q) begin
                lmfc_cnt_q  <= 5'h0; // see [RL5]
                phase_set_q <= 1'b1;
            end else begin
                // Free runs without SYSREF: no deterministic latency
                lmfc_cnt_q <= lmfc_wrap ? 5'h0 : lmfc_cnt_q + 5'h1; // see [RL6]
            end
        end
    end

    // ------------------------------------------------------------
    // Link state machine
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q   <= slss_pkg::ST_OFF;
            cal_cnt_q <= 16'h0;
            ila_cnt_q <= 3'h0;
        end else if (!link_enable_bit && state_q != slss_pkg::ST_CAL) begin
            state_q <= slss_pkg::ST_OFF; // see [RL1]
        end else begin
            case (state_q)
                slss_pkg::ST_OFF: begin
                    if (cal_req_q) begin
                        state_q   <= slss_pkg::ST_CAL; // see [RL3]
                        cal_cnt_q <= 16'(CAL_CYCLES - 1);
                    end else if (link_enable_bit) begin
                        state_q <= slss_pkg::ST_WAIT_SYNC; // see [RL4]
                    end
                end
                slss_pkg::ST_CAL: begin
                    if (cal_cnt_q == 16'h0) begin
                        state_q <= slss_pkg::ST_OFF;
                    end else begin
                        cal_cnt_q <= cal_cnt_q - 16'h1;
                    end
                end
                slss_pkg::ST_WAIT_SYNC: begin
                    if (!sync_n_s) begin
                        state_q <= slss_pkg::ST_CGS; // see [RL7]
                    end
                end
                slss_pkg::ST_CGS: begin
                    // Alignment starts on a multiframe boundary
                    if (sync_n_s && lmfc_wrap) begin
                        state_q   <= slss_pkg::ST_ILA; // see [RL8]
                        ila_cnt_q <= 3'h0;
                    end
                end
                slss_pkg::ST_ILA: begin
                    if (!sync_n_s) begin
                        state_q <= slss_pkg::ST_CGS;
                    end else if (lmfc_wrap) begin
                        if (ila_cnt_q == 3'(`SLSS_ILA_MFRAMES - 1)) begin
                            state_q <= slss_pkg::ST_DATA; // see [RL9]
                        end
                        ila_cnt_q <= ila_cnt_q + 3'h1;
                    end
                end
                slss_pkg::ST_DATA: begin
                    if (!sync_n_s) begin
                        state_q <= slss_pkg::ST_CGS; // see [RL10]
                    end
                end
                default: state_q <= slss_pkg::ST_OFF;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            link_on          <= 1'b0;
            lane_sym         <= slss_pkg::SYM_IDLE;
            lmfc_pulse       <= 1'b0;
            decimate_sel     <= 3'h0;
            scrambler_enable <= 1'b0;
            serial_ddr       <= 1'b0;
        end else begin
            // A pending trigger keeps the link down until calibration ends
            link_on          <= link_enable_bit && !cal_req_q
                                && state_q != slss_pkg::ST_CAL; // see [RL3]
            lmfc_pulse       <= lmfc_wrap;
            decimate_sel     <= conf_q[2:0];
            scrambler_enable <= conf_q[4];
            serial_ddr       <= conf_q[5];
            case (state_q)
                slss_pkg::ST_CGS:       lane_sym <= slss_pkg::SYM_CGS;
                slss_pkg::ST_WAIT_SYNC: lane_sym <= slss_pkg::SYM_CGS;
                slss_pkg::ST_ILA:       lane_sym <= slss_pkg::SYM_ILA;
                slss_pkg::ST_DATA:      lane_sym <= slss_pkg::SYM_DATA;
                default:                lane_sym <= slss_pkg::SYM_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_off_idle;
        @(posedge clk) disable iff (rst)
        (!link_enable_bit && state_q != slss_pkg::ST_CAL)
            |=> ##1 lane_sym == slss_pkg::SYM_IDLE;
    endproperty
    a_off_idle: assert property (p_off_idle) // see [RL1]
        else $error("link not idle while disabled");

    property p_conf_frozen;
        @(posedge clk) disable iff (rst)
        link_enable_bit |=> conf_q == $past(conf_q);
    endproperty
    a_conf_frozen: assert property (p_conf_frozen) // see [RL2]
        else $error("config changed while link enabled");

    property p_cal_len;
        @(posedge clk) disable iff (rst)
        $rose(state_q == slss_pkg::ST_CAL)
            |-> (state_q == slss_pkg::ST_CAL) [*8];
    endproperty
    a_cal_len: assert property (p_cal_len) // see [RL3]
        else $error("calibration ended too early");

    property p_enable;
        @(posedge clk) disable iff (rst)
        (state_q == slss_pkg::ST_OFF && link_enable_bit && !cal_req_q)
            |=> state_q == slss_pkg::ST_WAIT_SYNC;
    endproperty
    a_enable: assert property (p_enable) // see [RL4]
        else $error("link did not enable");

    property p_sysref;
        @(posedge clk) disable iff (rst)
        (link_enable_bit && sysref_s && !sysref_d_q)
            |=> lmfc_cnt_q == 5'h0 && phase_set_q;
    endproperty
    a_sysref: assert property (p_sysref) // see [RL5]
        else $error("multiframe phase not set by sysref");

    property p_ila_start;
        @(posedge clk) disable iff (rst)
        (state_q == slss_pkg::ST_CGS && sync_n_s && lmfc_wrap
         && link_enable_bit) |=> ##1 lane_sym == slss_pkg::SYM_ILA;
    endproperty
    a_ila_start: assert property (p_ila_start) // see [RL8]
        else $error("alignment did not start");

    property p_no_gap;
        @(posedge clk) disable iff (rst)
        (lane_sym == slss_pkg::SYM_ILA && state_q != slss_pkg::ST_ILA
         && $past(state_q) == slss_pkg::ST_ILA && sync_n_s
         && link_enable_bit)
            |-> state_q == slss_pkg::ST_DATA;
    endproperty
    a_no_gap: assert property (p_no_gap) // see [RL9]
        else $error("gap after alignment");

    property p_cgs;
        @(posedge clk) disable iff (rst)
        (state_q == slss_pkg::ST_DATA && !sync_n_s && link_enable_bit)
            |=> ##1 lane_sym == slss_pkg::SYM_CGS;
    endproperty
    a_cgs: assert property (p_cgs) // see [RL10]
        else $error("no sync characters while sync_n low");

    c_cal:  cover property (@(posedge clk) state_q == slss_pkg::ST_CAL);
    c_ila:  cover property (@(posedge clk) state_q == slss_pkg::ST_ILA);
    c_data: cover property (@(posedge clk) lane_sym == slss_pkg::SYM_DATA);
endmodule : slss_top

// ==== verif/slss_rx_model.sv ====
// Behavioural model of the serial link's data receiver
`timescale 1ns/100ps
module slss_rx_model (
    input  wire logic       clk,
    input  wire logic [1:0] lane_sym,
    output logic            sysref,
    output logic            sync_n
);
    initial begin
        sysref = 1'b0;
        sync_n = 1'b1;
    end
    // Callers skip this when latency need not be deterministic
    task automatic pulse_sysref();
        @(posedge clk);
        sysref <= 1'b1;
        repeat (4) @(posedge clk);
        sysref <= 1'b0;
    endtask : pulse_sysref
    // Low until sync characters arrive, then held a while as a slow receiver
    task automatic align(input int unsigned hold);
        int unsigned n;
        n = 0;
        @(posedge clk);
        sync_n <= 1'b0;
        while (lane_sym !== slss_pkg::SYM_CGS && n < 5000) begin
            @(posedge clk);
            n++;
        end
        repeat (hold) @(posedge clk);
        sync_n <= 1'b1;
    endtask : align
endmodule : slss_rx_model

// ==== verif/tb_top.sv ====
// Self-checking bench of the link startup sequencer
`timescale 1ns/100ps
`include "slss_cfg.svh"
module tb_top;
    localparam int CAL = 16;
    typedef struct {logic [31:0] d; logic [31:0] m;} slss_note_s;
    logic        clk, rst, cyc, stb, we, ack, sysref, sync_n, link_on;
    logic        lmfc, scr, ddr;
    logic [7:0]  adr;
    logic [31:0] wdat, rdat;
    logic [1:0]  sym, sym_last;
    logic [2:0]  dec;
    slss_note_s  rd_q[$];
    logic [1:0]  sym_q[$];
    int          errors, compares, cycles;

    slss_top #(.CAL_CYCLES(CAL)) i_dut (
        .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .sysref(sysref), .sync_n(sync_n),
        .link_on(link_on), .lane_sym(sym), .lmfc_pulse(lmfc),
        .decimate_sel(dec), .scrambler_enable(scr), .serial_ddr(ddr)
    );
    slss_rx_model i_rx (
        .clk(clk), .lane_sym(sym), .sysref(sysref), .sync_n(sync_n)
    );

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task automatic stop_test();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            errors++;
            stop_test();
        end
    end
    // Read data is judged at the ack edge, while the request still stands
    always @(posedge clk) begin
        if (!rst && ack === 1'b1 && !we) begin
            if (rd_q.size() == 0)
                cmp(rdat, ~rdat);
            else begin
                slss_note_s e;
                e = rd_q.pop_front();
                cmp(rdat & e.m, e.d);
            end
        end
    end
    // Every change of lane symbol must be the next one announced
    always @(posedge clk) begin
        if (rst)
            sym_last <= slss_pkg::SYM_IDLE;
        else if (sym !== sym_last) begin
            sym_last <= sym;
            cmp({30'h0, sym}, sym_q.size() ? {30'h0, sym_q.pop_front()} : 32'h4);
        end
    end

    // ------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : xfer
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m);
        rd_q.push_back('{e & m, m});
        xfer(1'b0, a, 32'h0);
    endtask : rd

    initial begin
        logic [31:0] v;
        int          n;
        {cyc, stb, we, adr, wdat} = '0;
        rst = 1'b1;
        {errors, compares, cycles} = '0;
        void'($urandom(93866));
        // Enable comes out of reset set, so sync characters show at once
        sym_q.push_back(slss_pkg::SYM_CGS);
        sym_q.push_back(slss_pkg::SYM_IDLE);
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd(`SLSS_OFS_CTRL, `SLSS_CTRL_RST, 32'h3);
        xfer(1'b1, `SLSS_OFS_CONF, 32'h0000_0005);
        rd(`SLSS_OFS_CONF, `SLSS_CONF_RST, 32'h1f37);
        rd(8'h0c, 32'h0, 32'hffff_ffff);
        rd(`SLSS_OFS_STAT, 32'h40, 32'hc0);
        for (int p = 0; p < 2; p++) begin
            xfer(1'b1, `SLSS_OFS_CTRL, 32'h0);
            repeat (2) @(posedge clk);
            cmp({31'h0, link_on}, 32'h0);
            v = $urandom & 32'h1f37;
            xfer(1'b1, `SLSS_OFS_CONF, v);
            rd(`SLSS_OFS_CONF, v, 32'h1f37);
            repeat (2) @(posedge clk);
            cmp({dec, scr, ddr}, {v[2:0], v[4], v[5]});
            sym_q.push_back(slss_pkg::SYM_CGS);
            xfer(1'b1, `SLSS_OFS_CTRL, 32'h3);
            n = 0;
            while (link_on !== 1'b1) begin
                @(posedge clk);
                n++;
            end
            cmp({31'h0, n >= CAL - 2}, 32'h1);
            // The second pass leaves the phasing edge out
            if (p == 0) begin
                i_rx.pulse_sysref();
                repeat (4) @(posedge clk);
                rd(`SLSS_OFS_STAT, 32'hc0, 32'hc0);
            end
            sym_q.push_back(slss_pkg::SYM_ILA);
            sym_q.push_back(slss_pkg::SYM_DATA);
            i_rx.align(10 + $urandom_range(30));
            while (sym !== slss_pkg::SYM_DATA) @(posedge clk);
            // Multiframe pulse period follows the programmed length
            while (lmfc !== 1'b1) @(posedge clk);
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (lmfc !== 1'b1);
            cmp(n, v[12:8] + 32'h1);
            repeat (20) @(posedge clk);
            sym_q.push_back(slss_pkg::SYM_IDLE);
        end
        xfer(1'b1, `SLSS_OFS_CTRL, 32'h0);
        repeat (6) @(posedge clk);
        cmp(sym_q.size(), 32'h0);
        stop_test();
    end
endmodule : tb_top
